// >>> pcc_host_model.sv
// far-side source of conversion ticks, word-rate ticks and voltage samples
`timescale 1ns/100ps
`default_nettype none

module pcc_host_model (
	input  wire logic        clk,
	input  wire logic        rst_n,
	output var  logic        conv_tick,
	output var  logic        word_tick,
	output var  logic [23:0] v_sample
);
	logic [2:0] div_q;
	// free-running divider: one conversion per 4 clocks, one word period per 8
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			div_q <= 3'h0;
		else
			div_q <= div_q + 3'h1;
	assign conv_tick = (div_q[1:0] == 2'h3);
	assign word_tick = (div_q == 3'h7);
	assign v_sample = 24'h000100;
endmodule : pcc_host_model

`default_nettype wire

// >>> pcc_pkg.sv
// package of constants, types and helpers for the paged config and calibration bank
package pcc_pkg;

	// ****************************************
	// widths and addresses
	// ****************************************
	localparam int         DATA_W           = 24;
	localparam logic [4:0] ADDR_PAGE        = 5'h1f;
	localparam logic [4:0] ADDR_PULSE_WIDTH = 5'h00;
	localparam logic [4:0] ADDR_NO_LOAD     = 5'h01;
	localparam logic [4:0] ADDR_TEMP_GAIN   = 5'h02;
	localparam logic [4:0] ADDR_TEMP_OFFSET = 5'h03;
	localparam logic [4:0] ADDR_DIP_DUR     = 5'h06;
	localparam logic [4:0] ADDR_DIP_LVL     = 5'h07;
	localparam logic [4:0] ADDR_FAULT_DUR   = 5'h0a;
	localparam logic [4:0] ADDR_FAULT_LVL   = 5'h0b;
	localparam logic [6:0] PAGE_CONFIG      = 7'h01;
	localparam logic [6:0] PAGE_EVENT       = 7'h03;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [6:0]  RST_PAGE        = 7'h00;
	localparam logic [23:0] RST_PULSE_WIDTH = 24'h000001;
	localparam logic [23:0] RST_NO_LOAD     = 24'h000000;
	localparam logic [23:0] RST_TEMP_GAIN   = 24'h2f03c3;
	localparam logic [23:0] RST_TEMP_OFFSET = 24'hf3d35a;
	localparam logic [23:0] RST_DIP_FAULT   = 24'h000000;
	localparam logic [23:0] RST_CAL_OFFSET  = 24'h000000;
	localparam logic [23:0] GAIN_UNITY      = 24'h400000;

	// ****************************************
	// calibration timing and arithmetic
	// ****************************************
	localparam logic [5:0]  CAL_SETTLE_TICKS = 6'h1e;
	localparam logic [2:0]  AC_OFFSET_SPAN   = 3'h6;
	localparam logic [23:0] AC_GAIN_TARGET   = 24'h4ccccd;
	localparam logic [23:0] GAIN_MAX         = 24'hffffff;
	localparam logic [23:0] POS_MAX          = 24'h7fffff;
	localparam logic [55:0] DC_GAIN_NUM      = 56'h00200000000000;
	localparam int          GAIN_FRAC        = 22;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [1:0] {CAL_DC_OFFSET, CAL_DC_GAIN, CAL_AC_OFFSET, CAL_AC_GAIN} pcc_cal_kind_e;
	typedef enum logic [1:0] {CS_IDLE, CS_SETTLE, CS_ACCUM, CS_DONE} pcc_cal_state_e;

	typedef struct packed {
		pcc_cal_kind_e kind;
		logic          chan_current;
	} pcc_cal_req_s;

	typedef struct packed {
		logic [23:0] v_dc_off;
		logic [23:0] v_gain;
		logic [23:0] v_ac_off;
		logic [23:0] i_dc_off;
		logic [23:0] i_gain;
		logic [23:0] i_ac_off;
	} pcc_cal_regs_s;

	typedef struct packed {
		logic [23:0] energy_pulse_width;
		logic [23:0] no_load_threshold;
		logic [23:0] temperature_gain;
		logic [23:0] temperature_offset;
		logic [23:0] voltage_dip_duration;
		logic [23:0] voltage_dip_level;
		logic [23:0] current_fault_duration;
		logic [23:0] current_fault_level;
	} pcc_cfg_s;

	// magnitude of a two's complement word, full scale negative maps to 0x800000
	function automatic logic [23:0] abs24(input logic [23:0] x);
		abs24 = x[23] ? (~x + 24'h000001) : x;
	endfunction : abs24

endpackage : pcc_pkg

// >>> pcc_regs.sv
// paged configuration register bank with calibration engine and energy pulse timing
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// (RULE1) write-only 7-bit page register at 31
// (RULE2) pulse width count sets pulse length
// (RULE3) host writes width 1 to 8388607
// (RULE4) small active power suppresses energy pulses
// (RULE5) host never writes negative threshold
// (RULE6) temperature gain register, unsigned, Celsius default
// (RULE7) temperature offset register, signed fraction
// (RULE8) sag and fault durations, zero disables
// (RULE9) duration sets averaged sample count
// (RULE10) averaged magnitude below level flags event
// (RULE11) levels unsigned, three integer bits
// (RULE12) offset and gain correct samples, rms
// (RULE13) separate calibration registers per channel
// (RULE14) host calibrates only when device active
// (RULE15) result stored, data-ready flag set
// (RULE16) mask gates data-ready onto interrupt
// (RULE17) existing ac gain and offset matter
// (RULE18) cycle count sets calibration conversions
// (RULE19) dc calibrations take N plus 30
// (RULE20) ac offset takes 6N plus 30
// (RULE21) accesses decode within selected page
module pcc_regs (
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	input  wire logic [4:0]            reg_addr,
	input  wire logic [23:0]           reg_wdata,
	output var  logic [23:0]           reg_rdata_q,
	output var  logic                  reg_rvalid_q,
	input  wire logic                  conv_tick,
	input  wire logic                  word_tick,
	input  wire logic [23:0]           v_sample,
	input  wire logic [23:0]           i_sample,
	input  wire logic [23:0]           v_rms,
	input  wire logic [23:0]           i_rms,
	input  wire logic [23:0]           active_power_result,
	input  wire logic                  energy_req,
	input  wire logic                  cal_start,
	input  wire pcc_pkg::pcc_cal_req_s cal_req,
	input  wire logic [23:0]           cycle_count,
	input  wire logic                  done_clear,
	input  wire logic                  done_mask,
	output var  logic                  energy_pulse_q,
	output var  logic [23:0]           v_inst_q,
	output var  logic [23:0]           i_inst_q,
	output var  logic [23:0]           v_rms_q,
	output var  logic [23:0]           i_rms_q,
	output var  pcc_pkg::pcc_cal_regs_s cal_regs_q,
	output var  pcc_pkg::pcc_cfg_s     cfg_q,
	output var  logic                  cal_busy_q,
	output var  logic                  conversion_done_flag_q,
	output var  logic                  int_q,
	output var  logic                  dip_q,
	output var  logic                  fault_q
);

	// ****************************************
	// reset synchroniser
	// ****************************************
	logic [1:0] rst_sync_q;
	logic       rst_n_s;

	// release is delayed two edges so the state register and both detectors leave reset together
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			rst_sync_q <= 2'h0;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end

	assign rst_n_s = rst_sync_q[1];

	// ****************************************
	// helpers
	// ****************************************
	// clamp a wide signed value into a 24-bit signed word
	function automatic logic [23:0] sat24(input logic signed [56:0] v);
		if (v > $signed({33'h0, pcc_pkg::POS_MAX}))
			sat24 = pcc_pkg::POS_MAX;
		else if (v < -$signed({33'h0, pcc_pkg::POS_MAX}) - 57'sd1)
			sat24 = 24'h800000;
		else
			sat24 = v[23:0];
	endfunction : sat24

	// offset then gain; gain has two integer bits so unity is 0x400000
	function automatic logic [23:0] correct(input logic [23:0] x, input logic [23:0] off, input logic [23:0] gain);
		logic signed [24:0] sum;
		logic signed [49:0] prod;
		sum  = $signed({x[23], x}) + $signed({off[23], off});
		prod = sum * $signed({1'b0, gain});
		correct = sat24(57'(prod >>> pcc_pkg::GAIN_FRAC));
	endfunction : correct

	// unsigned divide, a zero divisor returns all ones
	function automatic logic [55:0] udiv(input logic [55:0] num, input logic [55:0] den);
		udiv = (den == 56'h0) ? '1 : num / den;
	endfunction : udiv

	// clamp an unsigned quotient into a gain word
	function automatic logic [23:0] clamp_gain(input logic [55:0] q);
		clamp_gain = (q > {32'h0, pcc_pkg::GAIN_MAX}) ? pcc_pkg::GAIN_MAX : q[23:0];
	endfunction : clamp_gain

	// page-decoded read of the bank; the page register itself is write only
	function automatic logic [23:0] rd_word(input logic [6:0] page, input logic [4:0] a, input pcc_pkg::pcc_cfg_s c);
		rd_word = 24'h000000;
		if (page == pcc_pkg::PAGE_CONFIG)
		begin
			case (a)
				pcc_pkg::ADDR_PULSE_WIDTH: rd_word = c.energy_pulse_width;
				pcc_pkg::ADDR_NO_LOAD:     rd_word = c.no_load_threshold;
				pcc_pkg::ADDR_TEMP_GAIN:   rd_word = c.temperature_gain;
				pcc_pkg::ADDR_TEMP_OFFSET: rd_word = c.temperature_offset;
				default:                   rd_word = 24'h000000;
			endcase
		end
		else if (page == pcc_pkg::PAGE_EVENT)
		begin
			case (a)
				pcc_pkg::ADDR_DIP_DUR:   rd_word = c.voltage_dip_duration;
				pcc_pkg::ADDR_DIP_LVL:   rd_word = c.voltage_dip_level;
				pcc_pkg::ADDR_FAULT_DUR: rd_word = c.current_fault_duration;
				pcc_pkg::ADDR_FAULT_LVL: rd_word = c.current_fault_level;
				default:                 rd_word = 24'h000000;
			endcase
		end
	endfunction : rd_word

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [6:0]              page;
		pcc_pkg::pcc_cfg_s       cfg;
		pcc_pkg::pcc_cal_regs_s  cal;
		pcc_pkg::pcc_cal_state_e cs;
		pcc_pkg::pcc_cal_req_s   req;
		logic [5:0]              settle;
		logic [26:0]             target;
		logic [26:0]             taken;
		logic [55:0]             acc;
		logic [23:0]             rdata;
		logic                    rvalid;
		logic                    pulse;
		logic [22:0]             pulse_left;
		logic [23:0]             v_inst;
		logic [23:0]             i_inst;
		logic [23:0]             v_rms;
		logic [23:0]             i_rms;
		logic                    busy;
		logic                    done;
		logic                    irq;
	} pcc_regs_state_s;

	pcc_regs_state_s s_q;
	pcc_regs_state_s s_d;
	logic [23:0]     x_sel;
	logic [23:0]     dc_sel;
	logic [23:0]     gain_sel;
	logic [23:0]     ac_sel;
	logic [23:0]     c_sel;
	logic [55:0]     term;
	logic [55:0]     mag;
	logic [55:0]     quot;
	logic [23:0]     avg;
	logic [23:0]     result;
	logic [24:0]     ac_diff;
	logic            suppress;
	logic            done_evt;

	// ****************************************
	// next-state logic
	// ****************************************
	always_comb
	begin
		s_d      = s_q;
		s_d.rvalid = 1'b0;
		done_evt = 1'b0;
		result   = 24'h000000;
		ac_diff  = 25'h0;

		// (RULE13) each channel draws on its own registers
		x_sel    = s_q.req.chan_current ? i_sample : v_sample;
		dc_sel   = s_q.req.chan_current ? s_q.cal.i_dc_off : s_q.cal.v_dc_off;
		gain_sel = s_q.req.chan_current ? s_q.cal.i_gain : s_q.cal.v_gain;
		ac_sel   = s_q.req.chan_current ? s_q.cal.i_ac_off : s_q.cal.v_ac_off;
		// (RULE17) present gain shapes calibration samples
		c_sel    = correct(x_sel, dc_sel, gain_sel);
		if (s_q.req.kind == pcc_pkg::CAL_DC_OFFSET || s_q.req.kind == pcc_pkg::CAL_DC_GAIN)
			term = {{32{c_sel[23]}}, c_sel};
		else
			term = {32'h0, pcc_pkg::abs24(c_sel)};
		mag  = s_q.acc[55] ? (~s_q.acc + 56'h1) : s_q.acc;
		quot = udiv(mag, {29'h0, s_q.taken});
		avg  = s_q.acc[55] ? (~sat24({1'b0, quot}) + 24'h000001) : sat24({1'b0, quot});

		// (RULE21) writes decode within the selected page
		if (reg_wr)
		begin
			if (reg_addr == pcc_pkg::ADDR_PAGE)
				// (RULE1) page select write
				s_d.page = reg_wdata[6:0];
			else if (s_q.page == pcc_pkg::PAGE_CONFIG)
			begin
				case (reg_addr)
					// (RULE3) top bit held at zero
					pcc_pkg::ADDR_PULSE_WIDTH: s_d.cfg.energy_pulse_width = {1'b0, reg_wdata[22:0]};
					pcc_pkg::ADDR_NO_LOAD:     s_d.cfg.no_load_threshold  = reg_wdata;
					// (RULE6) temperature gain store
					pcc_pkg::ADDR_TEMP_GAIN:   s_d.cfg.temperature_gain   = reg_wdata;
					// (RULE7) temperature offset store
					pcc_pkg::ADDR_TEMP_OFFSET: s_d.cfg.temperature_offset = reg_wdata;
					default:                   s_d.cfg = s_q.cfg;
				endcase
			end
			else if (s_q.page == pcc_pkg::PAGE_EVENT)
			begin
				case (reg_addr)
					// (RULE8) duration registers, top bit zero
					pcc_pkg::ADDR_DIP_DUR:   s_d.cfg.voltage_dip_duration   = {1'b0, reg_wdata[22:0]};
					// (RULE11) unsigned level words
					pcc_pkg::ADDR_DIP_LVL:   s_d.cfg.voltage_dip_level      = reg_wdata;
					pcc_pkg::ADDR_FAULT_DUR: s_d.cfg.current_fault_duration = {1'b0, reg_wdata[22:0]};
					pcc_pkg::ADDR_FAULT_LVL: s_d.cfg.current_fault_level    = reg_wdata;
					default:                 s_d.cfg = s_q.cfg;
				endcase
			end
		end

		// (RULE21) reads decode within the selected page
		if (reg_rd)
		begin
			s_d.rvalid = 1'b1;
			s_d.rdata  = rd_word(s_q.page, reg_addr, s_q.cfg);
		end

		// (RULE12) corrected samples and rms each conversion
		if (conv_tick)
		begin
			s_d.v_inst = correct(v_sample, s_q.cal.v_dc_off, s_q.cal.v_gain);
			s_d.i_inst = correct(i_sample, s_q.cal.i_dc_off, s_q.cal.i_gain);
			s_d.v_rms  = (v_rms > s_q.cal.v_ac_off) ? v_rms - s_q.cal.v_ac_off : 24'h000000;
			s_d.i_rms  = (i_rms > s_q.cal.i_ac_off) ? i_rms - s_q.cal.i_ac_off : 24'h000000;
		end

		// calibration sequencer; a start while busy is ignored
		unique case (s_q.cs)
			pcc_pkg::CS_IDLE:
			begin
				// (RULE14) host starts only when active
				if (cal_start)
				begin
					s_d.req    = cal_req;
					s_d.busy   = 1'b1;
					s_d.settle = 6'h00;
					s_d.acc    = 56'h0;
					s_d.taken  = 27'h0;
					// (RULE18) cycle count sets sample count
					if (cal_req.kind == pcc_pkg::CAL_AC_OFFSET)
						// (RULE20) six windows for ac offset
						s_d.target = {3'h0, cycle_count} * {24'h000000, pcc_pkg::AC_OFFSET_SPAN};
					else
						s_d.target = {3'h0, cycle_count};
					if (cycle_count == 24'h000000)
						s_d.target = 27'h1;
					if (cal_req.kind == pcc_pkg::CAL_DC_GAIN)
					begin
						if (cal_req.chan_current)
							s_d.cal.i_gain = pcc_pkg::GAIN_UNITY;
						else
							s_d.cal.v_gain = pcc_pkg::GAIN_UNITY;
					end
					s_d.cs = pcc_pkg::CS_SETTLE;
				end
			end
			pcc_pkg::CS_SETTLE:
			begin
				// (RULE19) thirty settling conversions first
				if (conv_tick)
				begin
					if (s_q.settle == pcc_pkg::CAL_SETTLE_TICKS - 6'h01)
						s_d.cs = pcc_pkg::CS_ACCUM;
					else
						s_d.settle = s_q.settle + 6'h01;
				end
			end
			pcc_pkg::CS_ACCUM:
			begin
				if (conv_tick)
				begin
					s_d.acc   = s_q.acc + term;
					s_d.taken = s_q.taken + 27'h1;
					if (s_q.taken + 27'h1 >= s_q.target)
						s_d.cs = pcc_pkg::CS_DONE;
				end
			end
			pcc_pkg::CS_DONE:
			begin
				// (RULE17) prior offsets enter the result
				unique case (s_q.req.kind)
					pcc_pkg::CAL_DC_OFFSET:
						result = sat24(57'($signed({dc_sel[23], dc_sel}) - $signed({avg[23], avg})));
					pcc_pkg::CAL_DC_GAIN:
						result = avg[23] || avg == 24'h000000 ? pcc_pkg::GAIN_MAX
							: clamp_gain(udiv(pcc_pkg::DC_GAIN_NUM, {32'h0, avg}));
					pcc_pkg::CAL_AC_OFFSET:
						result = avg[23] ? pcc_pkg::POS_MAX : avg;
					pcc_pkg::CAL_AC_GAIN:
					begin
						ac_diff = {1'b0, avg} - {1'b0, ac_sel};
						result  = (ac_diff[24] || ac_diff == 25'h0) ? pcc_pkg::GAIN_MAX
							: clamp_gain(udiv(56'(gain_sel) * 56'(pcc_pkg::AC_GAIN_TARGET), {31'h0, ac_diff}));
					end
				endcase
				// (RULE15) store result in channel register
				unique case ({s_q.req.chan_current, s_q.req.kind == pcc_pkg::CAL_AC_OFFSET,
					s_q.req.kind == pcc_pkg::CAL_DC_OFFSET})
					3'b001:  s_d.cal.v_dc_off = result;
					3'b010:  s_d.cal.v_ac_off = result;
					3'b000:  s_d.cal.v_gain   = result;
					3'b101:  s_d.cal.i_dc_off = result;
					3'b110:  s_d.cal.i_ac_off = result;
					3'b100:  s_d.cal.i_gain   = result;
					default: s_d.cal = s_q.cal;
				endcase
				done_evt = 1'b1;
				s_d.busy = 1'b0;
				s_d.cs   = pcc_pkg::CS_IDLE;
			end
		endcase

		// (RULE15) completion sets data ready, set beats clear
		if (done_evt)
			s_d.done = 1'b1;
		else if (done_clear)
			s_d.done = 1'b0;
		// (RULE16) mask gates interrupt
		s_d.irq = s_d.done & done_mask;

		// (RULE4) no-load suppression
		suppress = !s_q.cfg.no_load_threshold[23]
			&& (pcc_pkg::abs24(active_power_result) < s_q.cfg.no_load_threshold);
		// (RULE2) pulse lasts width output-word periods
		if (!s_q.pulse)
		begin
			if (energy_req && !suppress)
			begin
				s_d.pulse      = 1'b1;
				s_d.pulse_left = (s_q.cfg.energy_pulse_width[22:0] == 23'h0) ? 23'h1
					: s_q.cfg.energy_pulse_width[22:0];
			end
		end
		else if (word_tick)
		begin
			if (s_q.pulse_left <= 23'h1)
				s_d.pulse = 1'b0;
			else
				s_d.pulse_left = s_q.pulse_left - 23'h1;
		end
	end

	// state register with documented reset values
	always_ff @(posedge clk or negedge rst_n_s)
	begin
		if (!rst_n_s)
		begin
			s_q      <= '0;
			s_q.page <= pcc_pkg::RST_PAGE;
			s_q.cfg  <= '{pcc_pkg::RST_PULSE_WIDTH, pcc_pkg::RST_NO_LOAD, pcc_pkg::RST_TEMP_GAIN,
				pcc_pkg::RST_TEMP_OFFSET, pcc_pkg::RST_DIP_FAULT, pcc_pkg::RST_DIP_FAULT,
				pcc_pkg::RST_DIP_FAULT, pcc_pkg::RST_DIP_FAULT};
			s_q.cal  <= '{pcc_pkg::RST_CAL_OFFSET, pcc_pkg::GAIN_UNITY, pcc_pkg::RST_CAL_OFFSET,
				pcc_pkg::RST_CAL_OFFSET, pcc_pkg::GAIN_UNITY, pcc_pkg::RST_CAL_OFFSET};
			s_q.cs   <= pcc_pkg::CS_IDLE;
		end
		else
			s_q <= s_d;
	end

	// ****************************************
	// sag and fault detectors
	// ****************************************
	// (RULE10) voltage dip detector
	pcc_sag_detect u_dip (
		.clk       (clk),
		.rst_n     (rst_n_s),
		.sample_en (conv_tick),
		.sample    (v_sample),
		.duration  (s_q.cfg.voltage_dip_duration),
		.level     (s_q.cfg.voltage_dip_level),
		.sag_q     (dip_q)
	);

	// (RULE10) current fault detector
	pcc_sag_detect u_fault (
		.clk       (clk),
		.rst_n     (rst_n_s),
		.sample_en (conv_tick),
		.sample    (i_sample),
		.duration  (s_q.cfg.current_fault_duration),
		.level     (s_q.cfg.current_fault_level),
		.sag_q     (fault_q)
	);

	// outputs straight from the state register
	assign reg_rdata_q            = s_q.rdata;
	assign reg_rvalid_q           = s_q.rvalid;
	assign energy_pulse_q         = s_q.pulse;
	assign v_inst_q               = s_q.v_inst;
	assign i_inst_q               = s_q.i_inst;
	assign v_rms_q                = s_q.v_rms;
	assign i_rms_q                = s_q.i_rms;
	assign cal_regs_q             = s_q.cal;
	assign cfg_q                  = s_q.cfg;
	assign cal_busy_q             = s_q.busy;
	assign conversion_done_flag_q = s_q.done;
	assign int_q                  = s_q.irq;

endmodule : pcc_regs

`default_nettype wire

// >>> pcc_regs_checker.sv
// assertion checker for the paged config and calibration bank
`timescale 1ns/100ps
`default_nettype none

module pcc_regs_checker (
	input wire logic              clk,
	input wire logic              rst_n,
	input wire logic              reg_rd,
	input wire logic [4:0]        reg_addr,
	input wire logic [23:0]       reg_rdata_q,
	input wire logic              reg_rvalid_q,
	input wire logic              conv_tick,
	input wire logic [23:0]       active_power_result,
	input wire logic              energy_req,
	input wire logic              cal_start,
	input wire logic              done_mask,
	input wire logic              energy_pulse_q,
	input wire pcc_pkg::pcc_cfg_s cfg_q,
	input wire logic              cal_busy_q,
	input wire logic              conversion_done_flag_q,
	input wire logic              int_q
);
	// ****************************************
	// helper logic
	// ****************************************
	logic [7:0]  tk_q;
	logic [23:0] mag;
	assign mag = active_power_result[23] ? -active_power_result : active_power_result;
	// conversions seen while busy, cleared on the first clock that busy is low
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			tk_q <= 8'h00;
		else if (!cal_busy_q)
			tk_q <= 8'h00;
		else if (conv_tick)
			tk_q <= tk_q + 8'h01;

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	// ****************************************
	// assertions
	// ****************************************
	AST_RD_ANSWER: assert property (reg_rd |=> reg_rvalid_q)
		else $error("read not answered");
	AST_RD_ONE: assert property (!$past(reg_rd) |-> !reg_rvalid_q)
		else $error("read valid without read");
	AST_PAGE_WO: assert property (reg_rd && reg_addr == pcc_pkg::ADDR_PAGE |=> reg_rdata_q == 24'h000000)
		else $error("page register readable");
	AST_WIDTH_TOP: assert property (cfg_q.energy_pulse_width[23] == 1'b0)
		else $error("pulse width top bit set");
	AST_DUR_TOP: assert property (!cfg_q.voltage_dip_duration[23] && !cfg_q.current_fault_duration[23])
		else $error("duration top bit set");
	AST_SUPPRESS: assert property (energy_req && !energy_pulse_q && !cfg_q.no_load_threshold[23]
		&& mag < cfg_q.no_load_threshold |=> !energy_pulse_q)
		else $error("pulse below no-load threshold");
	AST_PULSE_GO: assert property (energy_req && !energy_pulse_q && cfg_q.no_load_threshold == 24'h000000
		|=> energy_pulse_q)
		else $error("pulse not started");
	AST_CAL_GO: assert property (cal_start && !cal_busy_q |=> cal_busy_q)
		else $error("calibration not started");
	AST_CAL_LEN: assert property ($fell(cal_busy_q) |-> tk_q >= 8'd31)
		else $error("calibration too short");
	AST_CAL_FLAG: assert property ($fell(cal_busy_q) |-> conversion_done_flag_q)
		else $error("data ready not set at end");
	AST_INT: assert property (int_q == (conversion_done_flag_q & $past(done_mask)))
		else $error("interrupt not flag and mask");

	C_CAL: cover property ($fell(cal_busy_q));
	C_PULSE: cover property (energy_req ##1 energy_pulse_q);
	C_INT: cover property ($rose(int_q));
endmodule : pcc_regs_checker

bind pcc_regs pcc_regs_checker pcc_regs_checker_inst (.clk(clk), .rst_n(rst_n), .reg_rd(reg_rd),
	.reg_addr(reg_addr), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q), .conv_tick(conv_tick),
	.active_power_result(active_power_result), .energy_req(energy_req), .cal_start(cal_start),
	.done_mask(done_mask), .energy_pulse_q(energy_pulse_q), .cfg_q(cfg_q), .cal_busy_q(cal_busy_q),
	.conversion_done_flag_q(conversion_done_flag_q), .int_q(int_q));

`default_nettype wire

// >>> pcc_sag_detect.sv
// averaging sag / fault detector for one channel
`timescale 1ns/100ps
`default_nettype none

module pcc_sag_detect (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        sample_en,
	input  wire logic [23:0] sample,
	input  wire logic [23:0] duration,
	input  wire logic [23:0] level,
	output var  logic        sag_q
);

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [47:0] acc;
		logic [23:0] cnt;
		logic        sag;
	} pcc_sag_state_s;

	pcc_sag_state_s s_q;
	pcc_sag_state_s s_d;
	logic [47:0]    sum;
	logic [49:0]    limit;

	// window sum against duration*level; level has three integer bits, hence the factor four
	always_comb
	begin
		s_d   = s_q;
		sum   = s_q.acc + {24'h000000, pcc_pkg::abs24(sample)};
		limit = 50'(duration) * 50'(level) << 2;
		// (RULE8) zero duration disables
		if (duration == 24'h000000)
		begin
			s_d.acc = 48'h0;
			s_d.cnt = 24'h000000;
			s_d.sag = 1'b0;
		end
		else if (sample_en)
		begin
			// (RULE9) duration sets window length
			if (s_q.cnt + 24'h000001 >= duration)
			begin
				// (RULE10) average below level flags
				s_d.sag = {2'h0, sum} < limit;
				s_d.acc = 48'h0;
				s_d.cnt = 24'h000000;
			end
			else
			begin
				s_d.acc = sum;
				s_d.cnt = s_q.cnt + 24'h000001;
			end
		end
	end

	// state register
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign sag_q = s_q.sag;

endmodule : pcc_sag_detect

`default_nettype wire

// >>> tb_top.sv
// self-checking testbench for the paged config and calibration bank
`timescale 1ns/100ps
`default_nettype none

module tb_top;
	logic clk, rst_n, reg_wr, reg_rd, energy_req, cal_start, done_clear, done_mask, conv_tick, word_tick;
	logic reg_rvalid_q, energy_pulse_q, cal_busy_q, flag, int_q, dip_q, fault_q;
	logic [4:0] reg_addr;
	logic [23:0] reg_wdata, apr, v_sample, reg_rdata_q;
	pcc_pkg::pcc_cal_req_s cal_req;
	pcc_pkg::pcc_cal_regs_s cal_regs_q;
	pcc_pkg::pcc_cfg_s cfg_q;
	int miscompares, n_checks, cyc, bc;

	pcc_host_model pcc_host_model_inst (.clk(clk), .rst_n(rst_n), .conv_tick(conv_tick), .word_tick(word_tick),
		.v_sample(v_sample));
	pcc_regs pcc_regs_inst (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q), .conv_tick(conv_tick),
		.word_tick(word_tick), .v_sample(v_sample), .i_sample(24'h000200), .v_rms(24'h000000), .i_rms(24'h000000),
		.active_power_result(apr), .energy_req(energy_req), .cal_start(cal_start), .cal_req(cal_req),
		.cycle_count(24'h000002), .done_clear(done_clear), .done_mask(done_mask), .energy_pulse_q(energy_pulse_q),
		.v_inst_q(), .i_inst_q(), .v_rms_q(), .i_rms_q(), .cal_regs_q(cal_regs_q), .cfg_q(cfg_q),
		.cal_busy_q(cal_busy_q), .conversion_done_flag_q(flag), .int_q(int_q), .dip_q(dip_q), .fault_q(fault_q));

	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task report_and_stop;
		$display("comparisons %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : report_and_stop

	task automatic wr(input logic [4:0] a, input logic [23:0] d);
		@(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
		@(posedge clk) reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [4:0] a, input logic [23:0] exp, input string nm);
		@(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
		@(posedge clk) reg_rd <= 1'b0;
		#1 chk({nm, "_valid"}, reg_rvalid_q, 1);
		chk(nm, reg_rdata_q, exp);
	endtask : rd

	// request one pulse; width 3 word periods spans 17 to 24 clocks
	task automatic pulse(input logic exp);
		@(posedge clk) energy_req <= 1'b1;
		@(posedge clk) energy_req <= 1'b0;
		#1 chk("pulse_start", energy_pulse_q, exp);
		repeat (9) @(posedge clk);
		#1 chk("pulse_hold", energy_pulse_q, exp);
		repeat (30) @(posedge clk);
		#1 chk("pulse_end", energy_pulse_q, 0);
	endtask : pulse

	// run one calibration with N = 2 and time its busy span in clocks
	task automatic cal(input pcc_pkg::pcc_cal_kind_e k, input logic ch, input logic ie);
		@(posedge clk) {cal_start, cal_req} <= {1'b1, k, ch};
		@(posedge clk) cal_start <= 1'b0;
		#1 bc = 1;
		while (cal_busy_q === 1'b1 && bc < 2000)
		begin
			@(posedge clk);
			#1 bc++;
		end
		chk("cal_len", bc >= ((k == pcc_pkg::CAL_AC_OFFSET) ? 41 : 31) * 4, 1);
		chk("cal_flag", flag, 1);
		@(posedge clk) done_clear <= 1'b1;
		#1 chk("cal_int", int_q, ie);
		@(posedge clk) done_clear <= 1'b0;
		#1 chk("flag_clear", flag, 0);
	endtask : cal

	// cycle ceiling guards against a hang
	always @(posedge clk)
	begin
		cyc++;
		if (cyc > 20000)
		begin
			miscompares++;
			report_and_stop;
		end
	end

	initial
	begin
		{rst_n, reg_wr, reg_rd, energy_req, cal_start, done_clear, reg_addr, reg_wdata, apr, cal_req} = '0;
		done_mask = 1'b1;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		rd(pcc_pkg::ADDR_TEMP_GAIN, 0, "page0_read");
		wr(pcc_pkg::ADDR_PAGE, 24'h000001);
		rd(pcc_pkg::ADDR_PAGE, 0, "page_reg");
		rd(0, 1, "pulse_width");
		rd(1, 0, "no_load");
		rd(2, 24'h2f03c3, "temp_gain");
		rd(3, 24'hf3d35a, "temp_offset");
		wr(0, 24'h7fffff);
		rd(0, 24'h7fffff, "pw_top");
		$display("test config_page done");
		wr(0, 24'h000003);
		pulse(1);
		wr(1, 24'h100000);
		pulse(0);
		apr <= 24'hf00000;
		pulse(1);
		$display("test energy_pulse done");
		wr(pcc_pkg::ADDR_PAGE, 24'h000003);
		rd(6, 0, "dip_dur");
		rd(11, 0, "fault_lvl");
		chk("dip_off", dip_q, 0);
		wr(6, 24'h000004);
		wr(7, 24'h200000);
		wr(10, 24'h000004);
		wr(11, 24'h000040);
		repeat (60) @(posedge clk);
		#1 chk("dip_on", dip_q, 1);
		chk("fault_off", fault_q, 0);
		$display("test sag_fault done");
		cal(pcc_pkg::CAL_DC_OFFSET, 1'b0, 1'b1);
		chk("v_dc_off", cal_regs_q.v_dc_off, 24'hffff00);
		chk("i_dc_off", cal_regs_q.i_dc_off, 0);
		done_mask <= 1'b0;
		for (int k = 1; k < 4; k++)
			cal(pcc_pkg::pcc_cal_kind_e'(k), 1'b1, 1'b0);
		chk("v_dc_keep", cal_regs_q.v_dc_off, 24'hffff00);
		$display("test calibration done");
		report_and_stop;
	end
endmodule : tb_top

`default_nettype wire
